// *** logic/ctd_timer.v ***
// The AXI4-Lite interface to the registers was chosen for this implementation.
`include "ctd_map.vh"
`default_nettype none
module ctd_timer (
	input  wire        core_clk,
	input  wire        rst_b,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        lowClkPin,
	input  wire        lowerEventPin,
	input  wire        upperEventPin,
	output reg         lowerTimerOut,
	output reg         upperTimerOut,
	output reg         lowerMatchIrq,
	output reg         upperMatchIrq
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg  [7:0]  lowerCtrl_r, upperCtrl_r, lowerThr_r, upperThr_r, lowerPw_r, upperPw_r;
	reg  [2:0]  aux_r;
	reg  [7:0]  cnt5_r, cnt6_r;
	reg         ff5_r, ff6_r;
	reg  [10:0] pre_r;
	reg  [2:0]  fsDiv_r;
	reg  [2:0]  sync1_r, sync2_r, sync3_r;
	reg  [7:0]  awAddr_r;
	reg  [7:0]  wData_r;
	reg         wLane0_r;
	reg         awHave_r, wHave_r;

	wire [2:0] lMode  = lowerCtrl_r[`CTD_MODE_HI:`CTD_MODE_LO];
	wire [2:0] uMode  = upperCtrl_r[`CTD_MODE_HI:`CTD_MODE_LO];
	wire       is16   = uMode[2];
	wire       lRun   = is16 ? upperCtrl_r[`CTD_RUN_BIT] : lowerCtrl_r[`CTD_RUN_BIT];
	wire       uRun   = upperCtrl_r[`CTD_RUN_BIT];
	wire       slow   = aux_r[`CTD_AUX_SLOW];
	wire       outDis = aux_r[`CTD_AUX_OUT_DIS];
	wire       divSrc = aux_r[`CTD_AUX_DIV_SRC];

	// ----------------------------------------
	// Source ticks
	// ----------------------------------------
	// core_clk stands in for fc; fs arrives on a pin and is synchronised
	wire fsRise   = sync2_r[0] & ~sync3_r[0];
	wire lPinFall = ~sync2_r[1] & sync3_r[1];
	wire uPinFall = ~sync2_r[2] & sync3_r[2];
	wire fs8      = fsRise & (fsDiv_r == 3'h7);
	wire fcDiv11  = &pre_r[10:0];
	wire fcDiv7   = &pre_r[6:0];
	wire fcDiv5   = &pre_r[4:0];
	wire fcDiv3   = &pre_r[2:0];
	wire src0     = (divSrc || slow) ? fs8 : fcDiv11;
	wire [7:0] lTicks = {lPinFall, 1'b1, pre_r[0], fsRise, fcDiv3, fcDiv5, fcDiv7, src0};
	wire [7:0] uTicks = {uPinFall, 1'b1, pre_r[0], fsRise, fcDiv3, fcDiv5, fcDiv7, src0};
	wire       tick5, tickU;

	ctd_clk_sel lowerSel (
		.clkSel   (lowerCtrl_r[`CTD_CLK_HI:`CTD_CLK_LO]),
		.mode     (is16 ? uMode : lMode),
		.slowMode (slow),
		.ticks    (lTicks),
		.tick     (tick5)
	);

	ctd_clk_sel upperSel (
		.clkSel   (upperCtrl_r[`CTD_CLK_HI:`CTD_CLK_LO]),
		.mode     (uMode),
		.slowMode (slow),
		.ticks    (uTicks),
		.tick     (tickU)
	);

	// ----------------------------------------
	// Counting
	// ----------------------------------------
	wire [7:0]  cnt5Inc = cnt5_r + 8'h01;
	wire [7:0]  cnt6Inc = cnt6_r + 8'h01;
	wire [15:0] cnt16   = {cnt6_r, cnt5_r};
	wire [15:0] cnt16Inc = cnt16 + 16'h0001;
	wire [15:0] cmp16   = (uMode == `CTD_M_WARMUP) ? {upperThr_r, 8'h00} : {upperThr_r, lowerThr_r};
	wire        lRun5   = lRun & tick5;
	wire        ovf5    = lRun5 & (cnt5_r == 8'hff);
	wire        tick6   = uRun & (is16 ? ovf5 : tickU);
	wire        pwm5    = (lMode == `CTD_M_PWM8);
	wire        pwm6    = (uMode == `CTD_M_PWM8);
	wire        pwm16   = (uMode == `CTD_M_PWM16);
	wire        match5  = lRun5 & !pwm5 & (cnt5Inc == lowerThr_r);
	wire        match6  = tick6 & !pwm6 & (cnt6Inc == upperThr_r);
	wire        match16 = lRun5 & !pwm16 & (cnt16Inc == cmp16);
	wire        wrap16  = lRun5 & pwm16 & (cnt16 == 16'hffff);

	// ----------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------
	wire        doWrite = awHave_r & wHave_r & ~s_axi_bvalid;
	wire [5:0]  wIdx    = awAddr_r[7:2];
	wire        wCtrlL  = doWrite & wLane0_r & (wIdx == `CTD_IDX_LOWER_CTRL);
	wire        wCtrlU  = doWrite & wLane0_r & (wIdx == `CTD_IDX_UPPER_CTRL);
	reg         wMapped;
	always @*
	begin
		case (wIdx)
			`CTD_IDX_LOWER_CTRL, `CTD_IDX_UPPER_CTRL, `CTD_IDX_LOWER_THR,
			`CTD_IDX_UPPER_THR, `CTD_IDX_LOWER_PW, `CTD_IDX_UPPER_PW,
			`CTD_IDX_AUX_CTRL2:
				wMapped = 1'b1;
			default:
				wMapped = 1'b0;
		endcase
	end

	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `CTD_RESP_OKAY;
			awHave_r      <= 1'b0;
			wHave_r       <= 1'b0;
			awAddr_r      <= 8'h00;
			wData_r       <= 8'h00;
			wLane0_r      <= 1'b0;
			lowerCtrl_r   <= `CTD_CTRL_RESET;
			upperCtrl_r   <= `CTD_CTRL_RESET;
			lowerThr_r    <= 8'h00;
			upperThr_r    <= 8'h00;
			lowerPw_r     <= 8'h00;
			upperPw_r     <= 8'h00;
			aux_r         <= `CTD_AUX_RESET;
		end
		else
		begin
			// Ready is raised for one cycle, the cycle after valid, so each channel takes one item
			s_axi_awready <= ~awHave_r & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready  <= ~wHave_r & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHave_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHave_r  <= 1'b1;
				wData_r  <= s_axi_wdata[7:0];
				wLane0_r <= s_axi_wstrb[0];
			end
			if (doWrite)
			begin
				awHave_r     <= 1'b0;
				wHave_r      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wMapped ? `CTD_RESP_OKAY : `CTD_RESP_SLVERR;
				if (wLane0_r)
				begin
					case (wIdx)
						`CTD_IDX_LOWER_CTRL: lowerCtrl_r <= wData_r;
						`CTD_IDX_UPPER_CTRL: upperCtrl_r <= wData_r;
						`CTD_IDX_LOWER_THR:  lowerThr_r  <= wData_r;
						`CTD_IDX_UPPER_THR:  upperThr_r  <= wData_r;
						`CTD_IDX_LOWER_PW:   lowerPw_r   <= wData_r;
						`CTD_IDX_UPPER_PW:   upperPw_r   <= wData_r;
						`CTD_IDX_AUX_CTRL2:  aux_r       <= wData_r[2:0];
						default:             aux_r       <= aux_r;
					endcase
				end
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `CTD_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `CTD_RESP_OKAY;
				case (s_axi_araddr[7:2])
					`CTD_IDX_LOWER_CTRL: s_axi_rdata <= {24'h00_0000, lowerCtrl_r};
					`CTD_IDX_UPPER_CTRL: s_axi_rdata <= {24'h00_0000, upperCtrl_r};
					`CTD_IDX_LOWER_THR:  s_axi_rdata <= {24'h00_0000, lowerThr_r};
					`CTD_IDX_UPPER_THR:  s_axi_rdata <= {24'h00_0000, upperThr_r};
					`CTD_IDX_LOWER_PW:   s_axi_rdata <= {24'h00_0000, lowerPw_r};
					`CTD_IDX_UPPER_PW:   s_axi_rdata <= {24'h00_0000, upperPw_r};
					`CTD_IDX_AUX_CTRL2:  s_axi_rdata <= {29'h0000_0000, aux_r};
					`CTD_IDX_COUNT:      s_axi_rdata <= {16'h0000, cnt16};
					default:
					begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `CTD_RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Counters, flip-flops and pins
	// ----------------------------------------
	wire uPulseMode = (uMode == `CTD_M_PDO8) || pwm6 || pwm16 || (uMode == `CTD_M_PPG16);
	wire pwmHi6     = (uMode == `CTD_M_PPG16) ? (cnt16 < {upperPw_r, lowerPw_r}) :
		pwm16 ? (cnt16 < {upperPw_r, lowerPw_r}) : (cnt6_r < upperPw_r);
	reg  uLevel;
	always @*
	begin
		if (uMode == `CTD_M_PDO8)
			uLevel = ~ff6_r;
		else if (pwm6 || pwm16 || uMode == `CTD_M_PPG16)
			uLevel = pwmHi6 ? ff6_r : ~ff6_r;
		else
			uLevel = ff6_r;
	end

	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pre_r         <= 11'h000;
			fsDiv_r       <= 3'h0;
			sync1_r       <= 3'h0;
			sync2_r       <= 3'h0;
			sync3_r       <= 3'h0;
			cnt5_r        <= 8'h00;
			cnt6_r        <= 8'h00;
			ff5_r         <= 1'b0;
			ff6_r         <= 1'b0;
			lowerTimerOut <= 1'b0;
			upperTimerOut <= 1'b0;
			lowerMatchIrq <= 1'b0;
			upperMatchIrq <= 1'b0;
		end
		else
		begin
			pre_r   <= pre_r + 11'h001;
			sync1_r <= {upperEventPin, lowerEventPin, lowClkPin};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			if (fsRise)
				fsDiv_r <= fsDiv_r + 3'h1;
			// Lower counter
			if (!lRun)
				cnt5_r <= 8'h00;
			else if (is16 ? match16 : match5)
				cnt5_r <= 8'h00;
			else if (lRun5)
				cnt5_r <= cnt5Inc;
			// Upper counter
			if (!uRun)
				cnt6_r <= 8'h00;
			else if (is16 ? match16 : match6)
				cnt6_r <= 8'h00;
			else if (tick6)
				cnt6_r <= cnt6Inc;
			// Preset loads on a control write; a divider-mode match toggles
			if (wCtrlL)
				ff5_r <= wData_r[`CTD_FF_BIT];
			else if (match5 && !is16 && lMode == `CTD_M_PDO8)
				ff5_r <= ~ff5_r;
			if (wCtrlU)
				ff6_r <= wData_r[`CTD_FF_BIT];
			else if (match6 && uMode == `CTD_M_PDO8)
				ff6_r <= ~ff6_r;
			lowerMatchIrq <= ~is16 & match5;
			upperMatchIrq <= is16 ? (match16 | wrap16) : match6;
			lowerTimerOut <= (lMode == `CTD_M_PDO8) ? ~ff5_r :
				pwm5 ? ((cnt5_r < lowerPw_r) ? ff5_r : ~ff5_r) : ff5_r;
			upperTimerOut <= (uPulseMode && outDis) ? 1'b0 : uLevel;
		end
	end
endmodule
`default_nettype wire

// *** logic/ctd_map.vh ***
`ifndef CTD_MAP_VH
`define CTD_MAP_VH
// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define CTD_IDX_LOWER_CTRL  6'h1a
`define CTD_IDX_UPPER_CTRL  6'h1b
`define CTD_IDX_LOWER_THR   6'h1c
`define CTD_IDX_UPPER_THR   6'h1d
`define CTD_IDX_LOWER_PW    6'h1e
`define CTD_IDX_UPPER_PW    6'h1f
`define CTD_IDX_AUX_CTRL2   6'h20
`define CTD_IDX_COUNT       6'h21
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTD_FF_BIT          7
`define CTD_CLK_HI          6
`define CTD_CLK_LO          4
`define CTD_RUN_BIT         3
`define CTD_MODE_HI         2
`define CTD_MODE_LO         0
`define CTD_CTRL_RESET      8'h00
`define CTD_AUX_RESET       3'h0
// Aux control bits
`define CTD_AUX_OUT_DIS     0
`define CTD_AUX_DIV_SRC     1
`define CTD_AUX_SLOW        2
// ----------------------------------------
// Mode codes
// ----------------------------------------
`define CTD_M_TIMER8        3'h0
`define CTD_M_PDO8          3'h1
`define CTD_M_PWM8          3'h2
`define CTD_M_RSVD          3'h3
`define CTD_M_TIMER16       3'h4
`define CTD_M_WARMUP        3'h5
`define CTD_M_PWM16         3'h6
`define CTD_M_PPG16         3'h7
// ----------------------------------------
// Clock select codes
// ----------------------------------------
`define CTD_CK_DIV11        3'h0
`define CTD_CK_FS           3'h4
`define CTD_CK_FC           3'h6
`define CTD_CK_PIN          3'h7
`define CTD_CK_DIV3         3'h3
`define CTD_CK_FC2          3'h5
`define CTD_CK_FC_MAX       3'h6
// AXI responses
`define CTD_RESP_OKAY       2'b00
`define CTD_RESP_SLVERR     2'b10
`endif

// *** logic/ctd_clk_sel.v ***
`include "ctd_map.vh"
`default_nettype none
// Picks one counter source tick and blocks sources the mode may not use
module ctd_clk_sel (
	input  wire [2:0] clkSel,
	input  wire [2:0] mode,
	input  wire       slowMode,
	input  wire [7:0] ticks,
	output reg        tick
);
	reg allowed;
	always @*
	begin
		case (mode)
			`CTD_M_TIMER8, `CTD_M_TIMER16:
				allowed = (clkSel <= `CTD_CK_DIV3) || (clkSel == `CTD_CK_PIN);
			`CTD_M_PDO8, `CTD_M_PPG16:
				allowed = (clkSel <= `CTD_CK_DIV3);
			`CTD_M_PWM8, `CTD_M_PWM16:
				allowed = (clkSel <= `CTD_CK_FC_MAX);
			`CTD_M_WARMUP:
				allowed = (clkSel == `CTD_CK_FS) || (slowMode && clkSel == `CTD_CK_FC);
			default:
				allowed = 1'b0;
		endcase
		// Slow modes leave only fs/2^3, fs, the pin and warm-up fc
		if (slowMode && !(clkSel == `CTD_CK_DIV11 || clkSel == `CTD_CK_FS ||
			clkSel == `CTD_CK_PIN || (clkSel == `CTD_CK_FC && mode == `CTD_M_WARMUP)))
			allowed = 1'b0;
		tick = allowed & ticks[clkSel];
	end
endmodule
`default_nettype wire

// *** tb/ctd_timer_monitor.sv ***
`include "ctd_map.vh"
`default_nettype none
module ctd_timer_monitor (
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	// ----------------------------------------
	// Handshake steps
	// ----------------------------------------
	sequence s_rd_hs;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_b_wait;
		s_axi_bvalid && !s_axi_bready;
	endsequence
	sequence s_r_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	property p_aw_pulse;
		s_axi_awready |=> !s_axi_awready;
	endproperty
	a_aw_pulse: assert property (p_aw_pulse) else $error("awready held");
	property p_rd_answer;
		s_rd_hs |=> s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read late");
	property p_r_hold;
		s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_b_hold;
		s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_b_cause;
		$rose(s_axi_bvalid) |-> $past(s_axi_awvalid && s_axi_awready, 2)
			|| $past(s_axi_wvalid && s_axi_wready, 2);
	endproperty
	a_b_cause: assert property (p_b_cause) else $error("stray write response");
	property p_r_narrow;
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
	endproperty
	a_r_narrow: assert property (p_r_narrow) else $error("read upper bits set");
	property p_b_code;
		s_axi_bvalid |-> s_axi_bresp == `CTD_RESP_OKAY || s_axi_bresp == `CTD_RESP_SLVERR;
	endproperty
	a_b_code: assert property (p_b_code) else $error("bad write response");
	property p_ar_refused;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_refused: assert property (p_ar_refused) else $error("read taken early");
endmodule
`default_nettype wire

// *** tb/ctd_timer_tb_top.sv ***
`include "ctd_map.vh"
`default_nettype none
module ctd_timer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, lowerTimerOut, upperTimerOut, lowerMatchIrq, upperMatchIrq, ok;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, v;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
	logic [3:0]  s_axi_wstrb;
	logic [2:0]  div = 3'h0;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	int          err_count, checked, per, hi;
	// Aux, lower ctrl, lower thr, upper thr, upper ctrl, expected match period
	logic [7:0]  tAux [11] = '{0, 0, 0, 0, 2, 4, 0, 0, 0, 0, 4};
	logic [7:0]  tLc [11] = '{0, 0, 0, 0, 0, 0, 0, 8'h33, 8'h43, 8'h63, 8'h63};
	logic [7:0]  tLt [11] = '{0, 0, 0, 0, 0, 0, 0, 8'h10, 0, 8'h10, 0};
	logic [7:0]  tUt [11] = '{5, 2, 1, 1, 2, 1, 3, 1, 1, 1, 1};
	logic [7:0]  tUc [11] = '{8'h38, 8'h28, 8'h68, 8'h58, 8'h08, 8'h68,
		8'h78, 8'h0c, 8'h0d, 8'h0c, 8'h0d};
	int          tPer [11] = '{40, 64, 0, 0, 128, 0, 24, 2176, 2048, 0, 256};

	// Slow clock and both event pins share one divide-by-8 square wave
	ctd_timer dut_u (
		.core_clk      (core_clk),
		.rst_b         (rst_b),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.lowClkPin     (div[2]),
		.lowerEventPin (div[2]),
		.upperEventPin (div[2]),
		.lowerTimerOut (lowerTimerOut),
		.upperTimerOut (upperTimerOut),
		.lowerMatchIrq (lowerMatchIrq),
		.upperMatchIrq (upperMatchIrq)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
		div <= div + 3'h1;
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("BAD %s expected %h seen %h", nm, exp, got);
			err_count++;
		end
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] r);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid || s_axi_wvalid);
		s_axi_bready <= 1'b1;
		do
			@(posedge core_clk);
		while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		do
			@(posedge core_clk);
		while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do
			@(posedge core_clk);
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Cycles between two match pulses; 0 when none comes
	task automatic meas(input bit lo, output int p);
		int n;
		n = 0;
		p = 0;
		while ((lo ? lowerMatchIrq : upperMatchIrq) !== 1'b1 && n < 3000)
		begin
			@(negedge core_clk);
			n++;
		end
		if (n < 3000)
		begin
			n = 0;
			do
			begin
				@(negedge core_clk);
				n++;
			end while ((lo ? lowerMatchIrq : upperMatchIrq) !== 1'b1 && n < 3000);
			p = n;
		end
		// Hand back on a rising edge so the next bus call starts there
		@(posedge core_clk);
	endtask
	// Cycles out of 256 with the chosen timer output high
	task automatic hcount(input bit lo, output int h);
		h = 0;
		repeat (256)
		begin
			@(negedge core_clk);
			h += lo ? (lowerTimerOut === 1'b1) : (upperTimerOut === 1'b1);
		end
		@(posedge core_clk);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		{rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'h1;
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		rd(`CTD_IDX_UPPER_CTRL, rdv, rsp);
		chk("upper_reset", {24'h00_0000, `CTD_CTRL_RESET}, rdv);
		rd(`CTD_IDX_LOWER_CTRL, rdv, rsp);
		chk("lower_reset", 32'h0000_0000, rdv);
		for (int i = 0; i < 8; i++)
		begin
			v = {i[0], i[2:0], 1'b0, ~i[2:0]};
			wr(`CTD_IDX_UPPER_CTRL, v, rsp);
			rd(`CTD_IDX_UPPER_CTRL, rdv, rsp);
			chk("upper_rw", {24'h00_0000, v}, rdv);
			wr(`CTD_IDX_LOWER_CTRL, v ^ 8'hf7, rsp);
			rd(`CTD_IDX_LOWER_CTRL, rdv, rsp);
			chk("lower_rw", {24'h00_0000, v ^ 8'hf7}, rdv);
		end
		wr(`CTD_IDX_COUNT, 8'hff, rsp);
		chk("ro_write", {30'h0, `CTD_RESP_SLVERR}, {30'h0, rsp});
		rd(6'h3f, rdv, rsp);
		chk("unmapped_read", {30'h0, `CTD_RESP_SLVERR}, {30'h0, rsp});
		s_axi_wstrb <= 4'h0;
		wr(`CTD_IDX_UPPER_THR, 8'h99, rsp);
		s_axi_wstrb <= 4'h1;
		chk("strobe_resp", {30'h0, `CTD_RESP_OKAY}, {30'h0, rsp});
		rd(`CTD_IDX_UPPER_THR, rdv, rsp);
		chk("strobe_off", 32'h0000_0000, rdv);
		for (int c = 0; c < 11; c++)
		begin
			wr(`CTD_IDX_AUX_CTRL2, tAux[c], rsp);
			wr(`CTD_IDX_LOWER_THR, tLt[c], rsp);
			wr(`CTD_IDX_UPPER_THR, tUt[c], rsp);
			wr(`CTD_IDX_LOWER_CTRL, tLc[c], rsp);
			wr(`CTD_IDX_UPPER_CTRL, tUc[c], rsp);
			meas(1'b0, per);
			chk("period", tPer[c], per);
			wr(`CTD_IDX_UPPER_CTRL, tUc[c] & 8'hf7, rsp);
			rd(`CTD_IDX_COUNT, rdv, rsp);
			chk("count_clear", 32'h0000_0000, rdv);
		end
		wr(`CTD_IDX_UPPER_THR, 8'h04, rsp);
		for (int a = 1; a >= 0; a--)
		begin
			wr(`CTD_IDX_AUX_CTRL2, a[7:0], rsp);
			wr(`CTD_IDX_UPPER_CTRL, 8'h39, rsp);
			hcount(1'b0, hi);
			ok = a ? hi == 0 : hi > 64 && hi < 192;
			chk("pdo_out", 32'h0000_0001, {31'h0, ok});
			wr(`CTD_IDX_UPPER_CTRL, 8'h31, rsp);
		end
		// 8-bit PWM on fc: output high while the count is at or above the width
		wr(`CTD_IDX_UPPER_PW, 8'h40, rsp);
		wr(`CTD_IDX_UPPER_CTRL, 8'h6a, rsp);
		hcount(1'b0, hi);
		chk("pwm_width", 32'h0000_00c0, hi);
		wr(`CTD_IDX_UPPER_PW, 8'hc0, rsp);
		hcount(1'b0, hi);
		chk("pwm_new_width", 32'h0000_0040, hi);
		wr(`CTD_IDX_UPPER_CTRL, 8'h62, rsp);
		// Lower counter on its own: timer period, then divider output
		wr(`CTD_IDX_LOWER_THR, 8'h05, rsp);
		wr(`CTD_IDX_LOWER_CTRL, 8'h38, rsp);
		meas(1'b1, per);
		chk("lower_period", 32'h0000_0028, per);
		wr(`CTD_IDX_LOWER_CTRL, 8'h30, rsp);
		wr(`CTD_IDX_LOWER_THR, 8'h04, rsp);
		wr(`CTD_IDX_LOWER_CTRL, 8'h39, rsp);
		hcount(1'b1, hi);
		ok = hi > 64 && hi < 192;
		chk("lower_pdo", 32'h0000_0001, {31'h0, ok});
		wr(`CTD_IDX_LOWER_CTRL, 8'h31, rsp);
		report_and_stop();
	end
	// Longest run is well under half of this span
	initial
	begin
		repeat (80000) @(posedge core_clk);
		err_count++;
		report_and_stop();
	end
endmodule
bind ctd_timer ctd_timer_monitor mon_u (
	.core_clk      (core_clk),
	.rst_b         (rst_b),
	.s_axi_awvalid (s_axi_awvalid),
	.s_axi_awready (s_axi_awready),
	.s_axi_wvalid  (s_axi_wvalid),
	.s_axi_wready  (s_axi_wready),
	.s_axi_bresp   (s_axi_bresp),
	.s_axi_bvalid  (s_axi_bvalid),
	.s_axi_bready  (s_axi_bready),
	.s_axi_arvalid (s_axi_arvalid),
	.s_axi_arready (s_axi_arready),
	.s_axi_rdata   (s_axi_rdata),
	.s_axi_rresp   (s_axi_rresp),
	.s_axi_rvalid  (s_axi_rvalid),
	.s_axi_rready  (s_axi_rready)
);
`default_nettype wire
